// *** rtl/prm_map.vh ***
// Register offsets, field positions, reset values and timing for the paged register bank
`ifndef PRM_MAP_VH
`define PRM_MAP_VH
// ==========================================
// Address map
`define PRM_ADDR_W          8
`define PRM_DATA_W          8
`define PRM_PAGE_TOP        8'hEF
`define PRM_COMMON_BASE     8'hF0
`define PRM_OFS_OPERATION_CONTROL      8'hF0
`define PRM_OFS_INDIRECT    8'hFC
`define PRM_OFS_REGCTRL     8'hFF
`define PRM_COMMON_SEL      4:0
`define PRM_ROW_SEL         7:4
// ==========================================
// Register control fields
`define PRM_RC_PAGE         0
`define PRM_RC_BROADCAST_READ_ENABLE        2
`define PRM_RC_LOCK         5:4
`define PRM_RC_RDSRC        7
`define PRM_RC_RESET        8'h80
`define PRM_RC_WMASK        8'hB5
`define PRM_LOCK_NONE       2'h0
`define PRM_LOCK_REQ        2'h1
`define PRM_LOCK_DONE       2'h2
// ==========================================
// Operation control fields
`define PRM_OC_SLEEP        0
`define PRM_OC_CLR          1
`define PRM_OC_SINGLE_SHOT        2
`define PRM_OC_CONTINUOUS_MEASURE         3
`define PRM_OC_ADJ          5
`define PRM_OC_RST          7
`define PRM_OC_RESET        8'h00
`define PRM_OC_WMASK        8'hAF
// ==========================================
// Timing
`define PRM_CLK_HZ          25000000
`define PRM_ADJ_MAX_MS      100
`define PRM_ADJ_DONE_CYC    16
`endif

// *** rtl/prm_regbank.v ***
// Paged register bank with lock handshake and operation control sequencing
`timescale 1ns/1ps
`default_nettype none
`include "prm_map.vh"
module prm_regbank
#(
  parameter ADJ_CYCLES = `PRM_ADJ_DONE_CYC  // Config update latency, under 100 ms
)
(
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       clk_en,
  // Host register port
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire       burst_start,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output wire       reg_blocked,
  // Readback command
  input  wire       readback_req,
  input  wire       readback_bcast,
  output reg  [7:0] readback_data,
  output reg        readback_valid,
  output wire [7:0] readback_start_addr,
  // Map storage (page is address bit 8)
  output wire       map_wr,
  output wire [8:0] map_addr,
  output wire [7:0] map_wdata,
  input  wire [7:0] map_rdata,
  input  wire [7:0] fast_lsb,
  // Core measurement handshake
  input  wire       chip_select_low_pin,
  input  wire       meas_done,
  input  wire       map_update_pending,
  input  wire       reset_unlock,
  output wire       meas_run,
  output wire       accumulate_en,
  output reg        clear_accumulators,
  output reg        config_apply,
  output reg        device_reset,
  output wire       sleep_state,
  output wire       map_freeze,
  output wire [1:0] lock_field
);
  // ==========================================
  // Core states, one-hot
  localparam [3:0] ST_SLEEP = 4'h1;
  localparam [3:0] ST_STBY  = 4'h2;
  localparam [3:0] ST_MEAS  = 4'h4;
  localparam [3:0] ST_ADJ   = 4'h8;

  reg  [7:0] regctrl_ff;          // Register control
  reg  [7:0] nxt_regctrl;
  reg  [7:0] operation_control_ff;           // Operation control
  reg  [7:0] nxt_operation_control;
  reg  [7:0] indirect_address_ff; // Indirect readback start
  reg  [3:0] state_ff;            // Core state
  reg  [3:0] nxt_state;
  reg  [7:0] adj_cnt_ff;          // Config update timer
  reg  [7:0] nxt_adj_cnt;
  reg        cs_low_d_ff;         // Prior chip select level
  reg  [3:0] row_ff;              // Row held coherent in a burst
  reg        burst_ff;            // Burst active
  reg        nxt_clr_pulse;
  reg        nxt_adj_pulse;
  reg        nxt_rst_pulse;
  wire       cs_low_sync;         // Synchronised, high while chip select pin is low
  wire       common_hit;
  wire       lock_pending;
  wire       ctrl_wr;
  wire       op_wr;
  wire [7:0] oc_w;
  wire [1:0] lk_w;
  wire [7:0] acc_addr;            // Storage address, indirect during readback
  wire       acc_common;          // Storage address in common region
  wire [7:0] oc_set;              // Set requests carried by a host write

  // ==========================================
  // Pin synchroniser, inverted so its reset value matches an idle pin
  prm_sync2 u_cs_sync
  (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d_in    (~chip_select_low_pin),
    .q_out   (cs_low_sync)
  );

  // ==========================================
  // Decode
  assign common_hit   = (reg_addr >= `PRM_COMMON_BASE);
  assign lock_field   = regctrl_ff[`PRM_RC_LOCK];
  assign lock_pending = (lock_field == `PRM_LOCK_REQ);
  // Pending lock blocks everything but control and indirect address
  assign reg_blocked  = lock_pending && (reg_addr != `PRM_OFS_REGCTRL) &&
                        (reg_addr != `PRM_OFS_INDIRECT);
  assign ctrl_wr      = reg_wr && (reg_addr == `PRM_OFS_REGCTRL);
  assign op_wr        = reg_wr && (reg_addr == `PRM_OFS_OPERATION_CONTROL) && !reg_blocked;
  assign oc_w         = reg_wdata & `PRM_OC_WMASK;
  assign lk_w         = reg_wdata[`PRM_RC_LOCK];
  // A fresh request in the same cycle beats any self-clear
  assign oc_set       = op_wr ? oc_w : 8'h00;
  // Indirect readback presents the indirect address to storage
  assign acc_addr     = (readback_req && !regctrl_ff[`PRM_RC_RDSRC]) ? indirect_address_ff :
                        reg_addr;
  assign acc_common   = (acc_addr >= `PRM_COMMON_BASE);
  // Page bit extends the byte address for paged space
  assign map_addr     = {(acc_common ? 1'b0 : regctrl_ff[`PRM_RC_PAGE]), acc_addr};
  assign map_wr       = reg_wr && !common_hit && !reg_blocked;
  assign map_wdata    = reg_wdata;
  // Frozen while locked, or while a burst holds its row
  assign map_freeze   = (lock_field == `PRM_LOCK_DONE) || burst_ff;
  assign sleep_state  = (state_ff == ST_SLEEP);
  assign meas_run     = (state_ff == ST_MEAS);
  assign accumulate_en = (state_ff == ST_MEAS) && operation_control_ff[`PRM_OC_CONTINUOUS_MEASURE];
  assign readback_start_addr = indirect_address_ff;

  // ==========================================
  // Register control next value
  always @*
  begin
    nxt_regctrl = regctrl_ff;
    if (ctrl_wr)
    begin
      nxt_regctrl = reg_wdata & `PRM_RC_WMASK;
      // Host may request, release, or leave the lock; 11 is no request
      if (lk_w == `PRM_LOCK_REQ && lock_field == `PRM_LOCK_DONE)
        nxt_regctrl[`PRM_RC_LOCK] = `PRM_LOCK_DONE;
      else if (lk_w == `PRM_LOCK_REQ || lk_w == `PRM_LOCK_NONE)
        nxt_regctrl[`PRM_RC_LOCK] = lk_w;
      else
        nxt_regctrl[`PRM_RC_LOCK] = lock_field;
    end
    // Lock granted once pending updates have landed
    if (nxt_regctrl[`PRM_RC_LOCK] == `PRM_LOCK_REQ && !map_update_pending &&
        lock_pending)
      nxt_regctrl[`PRM_RC_LOCK] = `PRM_LOCK_DONE;
  end

  // ==========================================
  // Core sequencer and operation control next value
  always @*
  begin
    nxt_operation_control    = operation_control_ff;
    nxt_state     = state_ff;
    nxt_adj_cnt   = adj_cnt_ff;
    nxt_clr_pulse = 1'b0;
    nxt_adj_pulse = 1'b0;
    nxt_rst_pulse = 1'b0;
    if (op_wr)
    begin
      // Set-only bits only set; sleep and continuous follow the write
      nxt_operation_control[`PRM_OC_SLEEP] = oc_w[`PRM_OC_SLEEP];
      nxt_operation_control[`PRM_OC_CONTINUOUS_MEASURE]  = oc_w[`PRM_OC_CONTINUOUS_MEASURE];
      nxt_operation_control[`PRM_OC_CLR]   = operation_control_ff[`PRM_OC_CLR] | oc_w[`PRM_OC_CLR];
      nxt_operation_control[`PRM_OC_SINGLE_SHOT] = operation_control_ff[`PRM_OC_SINGLE_SHOT] | oc_w[`PRM_OC_SINGLE_SHOT];
      nxt_operation_control[`PRM_OC_ADJ]   = operation_control_ff[`PRM_OC_ADJ] | oc_w[`PRM_OC_ADJ];
      // Reset ignored unless unlocked
      if (oc_w[`PRM_OC_RST] && reset_unlock)
        nxt_rst_pulse = 1'b1;
    end
    // Clear acts at once and self-clears
    if (operation_control_ff[`PRM_OC_CLR])
    begin
      nxt_clr_pulse = 1'b1;
      nxt_operation_control[`PRM_OC_CLR] = oc_set[`PRM_OC_CLR];
    end
    case (state_ff)
      ST_SLEEP:
      begin
        // Falling chip select wakes the core
        if (cs_low_sync && !cs_low_d_ff)
        begin
          nxt_state = ST_STBY;
          nxt_operation_control[`PRM_OC_SLEEP] = oc_set[`PRM_OC_SLEEP];
        end
      end
      ST_STBY:
      begin
        if (operation_control_ff[`PRM_OC_SLEEP])
          nxt_state = ST_SLEEP;
        else if (operation_control_ff[`PRM_OC_ADJ])
        begin
          nxt_state   = ST_ADJ;
          nxt_adj_cnt = ADJ_CYCLES[7:0];
        end
        else if (operation_control_ff[`PRM_OC_SINGLE_SHOT] || operation_control_ff[`PRM_OC_CONTINUOUS_MEASURE])
          nxt_state = ST_MEAS;
      end
      ST_MEAS:
      begin
        if (meas_done)
        begin
          if (operation_control_ff[`PRM_OC_SINGLE_SHOT] && operation_control_ff[`PRM_OC_CONTINUOUS_MEASURE])
            nxt_operation_control[`PRM_OC_CONTINUOUS_MEASURE] = oc_set[`PRM_OC_CONTINUOUS_MEASURE];
          else if (operation_control_ff[`PRM_OC_SINGLE_SHOT])
          begin
            nxt_operation_control[`PRM_OC_SINGLE_SHOT] = oc_set[`PRM_OC_SINGLE_SHOT];
            nxt_state = ST_STBY;
          end
          else if (!operation_control_ff[`PRM_OC_CONTINUOUS_MEASURE])
            nxt_state = ST_STBY;
        end
      end
      ST_ADJ:
      begin
        if (adj_cnt_ff == 8'h00)
        begin
          nxt_adj_pulse = 1'b1;
          nxt_operation_control[`PRM_OC_ADJ] = oc_set[`PRM_OC_ADJ];
          nxt_state = ST_STBY;
        end
        else
          nxt_adj_cnt = adj_cnt_ff - 8'h01;
      end
      default:
        nxt_state = ST_STBY;
    endcase
  end

  // ==========================================
  // State registers
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regctrl_ff          <= `PRM_RC_RESET;
      operation_control_ff           <= `PRM_OC_RESET;
      indirect_address_ff <= 8'h00;
      state_ff            <= ST_STBY;
      adj_cnt_ff          <= 8'h00;
      cs_low_d_ff         <= 1'b0;
      row_ff              <= 4'h0;
      burst_ff            <= 1'b0;
      clear_accumulators  <= 1'b0;
      config_apply        <= 1'b0;
      device_reset        <= 1'b0;
    end
    else if (clk_en)
    begin
      regctrl_ff         <= nxt_regctrl;
      operation_control_ff          <= nxt_operation_control;
      state_ff           <= nxt_state;
      adj_cnt_ff         <= nxt_adj_cnt;
      cs_low_d_ff        <= cs_low_sync;
      clear_accumulators <= nxt_clr_pulse;
      config_apply       <= nxt_adj_pulse;
      device_reset       <= nxt_rst_pulse;
      if (reg_wr && reg_addr == `PRM_OFS_INDIRECT)
        indirect_address_ff <= reg_wdata;
      // Burst holds the map while it stays in its row
      if (burst_start)
      begin
        burst_ff <= 1'b1;
        row_ff   <= reg_addr[`PRM_ROW_SEL];
      end
      else if ((reg_rd || reg_wr) && reg_addr[`PRM_ROW_SEL] != row_ff)
        burst_ff <= 1'b0;
      else if (!(reg_rd || reg_wr))
        burst_ff <= 1'b0;
    end
  end

  // ==========================================
  // Read data, registered; blocked reads return all ones
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (clk_en && reg_rd)
    begin
      if (reg_blocked)
        reg_rdata <= 8'hFF;
      else if (reg_addr == `PRM_OFS_REGCTRL)
        reg_rdata <= regctrl_ff;
      else if (reg_addr == `PRM_OFS_OPERATION_CONTROL)
        reg_rdata <= operation_control_ff;
      else if (reg_addr == `PRM_OFS_INDIRECT)
        reg_rdata <= indirect_address_ff;
      else
        reg_rdata <= map_rdata;
    end
  end

  // ==========================================
  // Readback command response
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readback_data  <= 8'h00;
      readback_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      // Broadcast answered only when enabled
      readback_valid <= readback_req &&
                        (!readback_bcast || regctrl_ff[`PRM_RC_BROADCAST_READ_ENABLE]);
      if (regctrl_ff[`PRM_RC_RDSRC])
        readback_data <= fast_lsb;
      else
        readback_data <= map_rdata;
    end
  end
endmodule
`default_nettype wire

// *** rtl/prm_sync2.v ***
// Two flip-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
`default_nettype none
module prm_sync2
(
  input  wire sys_clk,
  input  wire rst_b,
  input  wire d_in,
  output wire q_out
);
  // ==========================================
  // Synchroniser stages
  reg meta_ff;   // First stage, read only by second
  reg sync_ff;   // Second stage
  // Shift the input through two stages
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end
  assign q_out = sync_ff;
endmodule
`default_nettype wire

// *** tb/prm_core_model.sv ***
// Core-side model: paged map storage and measurement timing
`timescale 1ns/1ps
`default_nettype none
module prm_core_model
#(
  parameter MEAS_CYC = 5  // Measurement count limit; one set lasts MEAS_CYC+1 cycles
)
(
  input  wire logic       sys_clk,
  input  wire logic       map_wr,
  input  wire logic [8:0] map_addr,
  input  wire logic [7:0] map_wdata,
  output wire logic [7:0] map_rdata,
  input  wire logic       meas_run,
  output var  logic       meas_done
);
  logic [7:0] mem [0:511];  // Both pages, page is address bit 8
  int         cnt;          // Measurement progress
  // Seed storage with address-derived bytes
  initial
  begin
    meas_done = 1'b0;
    cnt = 0;
    for (int i = 0; i < 512; i++)
      mem[i] = 8'(i) ^ 8'h3C;
  end
  assign map_rdata = mem[map_addr];
  // Stores host bytes; a set ends MEAS_CYC+1 cycles after start
  always @(posedge sys_clk)
  begin
    if (map_wr)
      mem[map_addr] <= map_wdata;
    meas_done <= meas_run && cnt == MEAS_CYC;
    cnt <= (meas_run && cnt < MEAS_CYC) ? cnt + 1 : 0;
  end
endmodule
`default_nettype wire

// *** tb/prm_regbank_bench.sv ***
// Self-checking bench for the paged register bank
`timescale 1ns/1ps
`default_nettype none
module prm_regbank_bench;
  logic       sys_clk, rst_b, reg_wr, reg_rd, rb_req, rb_bc, cs_pin, pending, unlock, blk_seen;
  logic [7:0] reg_addr, reg_wdata, d;
  logic [3:0] seen;  // Sticky pulse flags
  logic       bst;   // Burst start strobe
  int         num_errors, n_checks;
  wire  logic [7:0] reg_rdata, rb_data, rb_start, map_rdata, map_wdata;
  wire  logic [8:0] map_addr;
  wire  logic [1:0] lock_f;
  wire  logic       blocked, rb_valid, map_wr, meas_done, meas_run, acc_en;
  wire  logic       clr_p, cfg_p, rst_p, sleep_st, freeze;
  prm_regbank #(.ADJ_CYCLES(4)) i_dut
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .burst_start(bst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_blocked(blocked), .readback_req(rb_req), .readback_bcast(rb_bc),
    .readback_data(rb_data), .readback_valid(rb_valid), .readback_start_addr(rb_start),
    .map_wr(map_wr), .map_addr(map_addr), .map_wdata(map_wdata), .map_rdata(map_rdata),
    .fast_lsb(8'hA7), .chip_select_low_pin(cs_pin), .meas_done(meas_done),
    .map_update_pending(pending), .reset_unlock(unlock), .meas_run(meas_run),
    .accumulate_en(acc_en), .clear_accumulators(clr_p), .config_apply(cfg_p),
    .device_reset(rst_p), .sleep_state(sleep_st), .map_freeze(freeze), .lock_field(lock_f)
  );
  prm_core_model #(.MEAS_CYC(5)) i_core
  (
    .sys_clk(sys_clk), .map_wr(map_wr), .map_addr(map_addr), .map_wdata(map_wdata),
    .map_rdata(map_rdata), .meas_run(meas_run), .meas_done(meas_done)
  );
  // ==========================================
  // Clock and pulse capture
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    seen <= seen | {meas_run, rst_p, cfg_p, clr_p};
  // ==========================================
  // Bus tasks
  task automatic check(input string n, input logic [7:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read one byte into d; blk_seen holds the refusal flag
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    #1 blk_seen = blocked;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, e);
    rd(a);
    check(n, d, e);
  endtask
  // Bounded poll until masked bits match
  task automatic poll(input logic [7:0] a, m, e);
    int i;
    for (i = 0; i < 100; i++)
    begin
      rd(a);
      if ((d & m) === e)
        break;
    end
    check("poll", d & m, e);
    if (i == 100)
      tally_and_finish();
  endtask
  task automatic rbk(input logic b, v, input logic [7:0] e);
    @(posedge sys_clk);
    rb_req <= 1'b1;
    rb_bc <= b;
    @(posedge sys_clk);
    rb_req <= 1'b0;
    #1 check("rb valid", {7'h00, rb_valid}, {7'h00, v});
    if (v)
      check("rb data", rb_data, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_pages();
    rdc("ctl reset", 8'hFF, 8'h80);
    rdc("op reset", 8'hF0, 8'h00);
    wr(8'h10, 8'h5A);
    wr(8'hFF, 8'h01);
    wr(8'h10, 8'hC3);
    wr(8'hFC, 8'h10);
    rdc("page1", 8'h10, 8'hC3);
    wr(8'hFF, 8'h04);
    rdc("page0", 8'h10, 8'h5A);
    rdc("common", 8'hFC, 8'h10);
    rdc("ctl", 8'hFF, 8'h04);
    check("rb start", rb_start, 8'h10);
    rbk(1'b0, 1'b1, 8'h5A);
    rbk(1'b1, 1'b1, 8'h5A);
    wr(8'hFF, 8'h80);
    rbk(1'b1, 1'b0, 8'h00);
    rbk(1'b0, 1'b1, 8'hA7);
    $display("done paging");
  endtask
  task automatic t_lock();
    pending <= 1'b1;
    wr(8'hFF, 8'h90);
    rdc("lock req", 8'hFF, 8'h90);
    wr(8'h20, 8'h11);
    rdc("refused", 8'h20, 8'hFF);
    check("blocked", {7'h00, blk_seen}, 8'h01);
    rdc("indirect", 8'hFC, 8'h10);
    pending <= 1'b0;
    poll(8'hFF, 8'h30, 8'h20);
    check("frozen", {7'h00, freeze}, 8'h01);
    rdc("untouched", 8'h20, 8'h1C);
    wr(8'h20, 8'h77);
    rdc("preset", 8'h20, 8'h77);
    wr(8'hFF, 8'h80);
    wr(8'hFF, 8'hB0);
    rdc("lock 11", 8'hFF, 8'h80);
    $display("done lock");
  endtask
  // Back-to-back reads in one row hold the map, leaving the row releases it
  task automatic t_burst();
    @(posedge sys_clk);
    {bst, reg_rd, reg_addr} <= {2'b11, 8'h30};
    @(posedge sys_clk);
    {bst, reg_addr} <= {1'b0, 8'h31};
    #1 check("burst hold", {7'h00, freeze}, 8'h01);
    @(posedge sys_clk);
    reg_addr <= 8'h41;
    #1 check("burst byte", reg_rdata, 8'h0D);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check("burst end", {7'h00, freeze}, 8'h00);
    check("burst exit byte", reg_rdata, 8'h7D);
    $display("done burst");
  endtask
  task automatic t_ops();
    wr(8'hF0, 8'h02);
    poll(8'hF0, 8'h02, 8'h00);
    check("clear", {7'h00, seen[0]}, 8'h01);
    wr(8'hF0, 8'h04);
    poll(8'hF0, 8'h04, 8'h00);
    check("measured", {7'h00, seen[3]}, 8'h01);
    wr(8'hF0, 8'h08);
    repeat (3) @(posedge sys_clk);
    #1 check("accum on", {7'h00, acc_en}, 8'h01);
    wr(8'hF0, 8'h0C);
    poll(8'hF0, 8'h0C, 8'h00);
    check("accum off", {7'h00, acc_en}, 8'h00);
    wr(8'hF0, 8'h20);
    poll(8'hF0, 8'h20, 8'h00);
    check("cfg apply", {7'h00, seen[1]}, 8'h01);
    wr(8'hF0, 8'h01);
    repeat (3) @(posedge sys_clk);
    #1 check("asleep", {7'h00, sleep_st}, 8'h01);
    cs_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    cs_pin <= 1'b1;
    #1 check("awake", {7'h00, sleep_st}, 8'h00);
    wr(8'hF0, 8'h80);
    repeat (4) @(posedge sys_clk);
    rdc("rst ignored", 8'hF0, 8'h00);
    check("no reset", {7'h00, seen[2]}, 8'h00);
    unlock <= 1'b1;
    wr(8'hF0, 8'h80);
    repeat (4) @(posedge sys_clk);
    check("reset", {7'h00, seen[2]}, 8'h01);
    $display("done operation control");
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {rst_b, reg_wr, reg_rd, rb_req, rb_bc, pending, unlock, blk_seen, bst} = 9'h000;
    {cs_pin, reg_addr, reg_wdata, seen} = 21'h100000;  // Pin idles high
    num_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_pages();
    t_lock();
    t_burst();
    t_ops();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** tb/prm_regbank_monitor.sv ***
// Port checker for the paged register bank
`timescale 1ns/1ps
`default_nettype none
module prm_regbank_monitor
#(
  parameter ADJ_CYCLES = 16  // Config update latency
)
(
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_blocked,
  input wire logic       readback_req,
  input wire logic       readback_bcast,
  input wire logic       readback_valid,
  input wire logic       map_wr,
  input wire logic [8:0] map_addr,
  input wire logic       map_update_pending,
  input wire logic       reset_unlock,
  input wire logic       clear_accumulators,
  input wire logic       device_reset,
  input wire logic       map_freeze,
  input wire logic [1:0] lock_field
);
  // ==========================================
  // Helpers
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Host write to the control register
  wire ctl_wr = reg_wr & (reg_addr == 8'hFF);
  // Access that a pending lock must refuse
  wire guard = (lock_field == 2'h1) & (reg_addr != 8'hFF) & (reg_addr != 8'hFC);
  // Pending lock with nothing left to update
  wire grant_due = (lock_field == 2'h1) & !map_update_pending & !ctl_wr;
  // Accepted clear request
  wire clr_req = reg_wr & !reg_blocked & (reg_addr == 8'hF0) & reg_wdata[1];
  // ==========================================
  // Assertions
  chk_block_decode: assert property ((reg_wr | reg_rd) |-> reg_blocked == guard)
    else $error("block flag wrong");
  chk_block_read: assert property (reg_rd & reg_blocked |=> reg_rdata == 8'hFF)
    else $error("blocked read not all ones");
  chk_map_decode: assert property (reg_wr & !reg_blocked & reg_addr < 8'hF0 |-> map_wr)
    else $error("page write lost");
  chk_map_range: assert property (map_wr |-> map_addr[7:0] == reg_addr && reg_addr <= 8'hEF)
    else $error("common address reached paged storage");
  chk_rb_latency: assert property (readback_req & !readback_bcast |=> readback_valid)
    else $error("readback late");
  chk_rb_quiet: assert property (!readback_req |=> !readback_valid)
    else $error("readback without request");
  chk_lock_grant: assert property (grant_due |=> lock_field == 2'h2)
    else $error("lock not granted");
  chk_lock_hold: assert property (lock_field == 2'h2 & !ctl_wr |=> lock_field == 2'h2)
    else $error("lock dropped");
  chk_lock_freeze: assert property (lock_field == 2'h2 |-> map_freeze)
    else $error("map not frozen");
  chk_reset_guard: assert property ((!reset_unlock) [*3] |-> !device_reset)
    else $error("reset while not unlocked");
  chk_clear_pulse: assert property (clr_req |-> ##[1:3] clear_accumulators)
    else $error("clear pulse missing");
  cov_locked: cover property (lock_field == 2'h2);
  cov_clear: cover property (clear_accumulators);
  cov_block: cover property (reg_rd & reg_blocked);
endmodule
bind prm_regbank prm_regbank_monitor #(.ADJ_CYCLES(ADJ_CYCLES)) u_mon
(
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_blocked(reg_blocked),
  .readback_req(readback_req), .readback_bcast(readback_bcast),
  .readback_valid(readback_valid), .map_wr(map_wr), .map_addr(map_addr),
  .map_update_pending(map_update_pending), .reset_unlock(reset_unlock),
  .clear_accumulators(clear_accumulators), .device_reset(device_reset),
  .map_freeze(map_freeze), .lock_field(lock_field)
);
`default_nettype wire
